// *** hw/crpm_defines.svh ***
// Register offsets, field positions, reset values and timing counts.
// Included by the controller; definitions only.
`ifndef CRPM_DEFINES_SVH
`define CRPM_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_MODE 8'h00
`define OFS_CLK 8'h04
`define OFS_WAKE 8'h08
`define OFS_WDT 8'h0C
`define OFS_SERVICE 8'h10
`define OFS_CAUSE 8'h14
`define OFS_SWRST 8'h18
`define OFS_STAT 8'h1C
`define DIV_HI 4'h2

// ****************************************
// Field positions
// ****************************************
`define MODE_F 1:0
`define CLK_SEL_F 1:0
`define CLK_FREQ_F 6:4
`define WMASK_F 7:0
`define TOUCH_EN_B 8
`define WDT_TO_F 15:0
`define WDT_EN_B 16
`define CAUSE_F 3:0
`define CAUSE_WDT 0
`define CAUSE_SW 1
`define CAUSE_EXTERNAL_RESET_N 2
`define CAUSE_BOD 3
`define SWRST_B 0
`define STAT_SRC_F 3:2
`define STAT_SW_B 4
`define STAT_SG_B 5
`define DIV_INT_F 23:0
`define DIV_FRAC_B 31

// ****************************************
// Reset values and timing
// ****************************************
`define FREQ_MAX 3'h6
`define WDT_TO_RST 16'hFFFF
`define PINS_RST 6'h04
`define RST_PULSE 8'h10
`define WAKE_TIME_NS 35000
`define CLK_PERIOD_NS 4

`endif

// *** hw/crpm_pkg.sv ***
// Types shared by the clock, reset and power-mode controller.
// Assumes nothing of its surroundings.
package crpm_pkg;

    // Power modes; WAKE is the oscillator restart leg out of deep sleep
    typedef enum logic [1:0] {MODE_ACTIVE, MODE_SLEEP, MODE_DEEP, MODE_WAKE} power_mode_type;

    // Clock sources for the root clock
    typedef enum logic [1:0] {SRC_MAIN, SRC_LP, SRC_EXT, SRC_RSVD} clk_src_type;

    // Glitch-free switch steps
    typedef enum logic [1:0] {MUX_RUN, MUX_DRAIN, MUX_FILL} mux_state_type;

    // Asynchronous pin and oscillator levels
    typedef struct packed {
        logic main_osc;
        logic lp_osc;
        logic ext_clk;
        logic ext_rst_n;
        logic supply_good;
        logic brown_out;
    } pins_type;

    // One divider setting
    typedef struct packed {
        logic frac;
        logic [23:0] int_part;
    } div_cfg_type;

endpackage : crpm_pkg

// *** hw/clock_reset_power_mode_control.sv ***
// Clock source switch, dividers, power modes, watchdog and reset cause.
// Assumes one clock hclk; oscillators and pins arrive asynchronously.
`include "crpm_defines.svh"

module clock_reset_power_mode_control
    import crpm_pkg::*;
#(
    parameter int WAKE_CYCLES = `WAKE_TIME_NS / `CLK_PERIOD_NS,
    parameter int DIV_INT_W [4] = '{16, 16, 16, 24},
    parameter logic [3:0] DIV_FRAC = 4'hC
) (
    // Clock and resets
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic por_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Asynchronous pins and oscillators
    input wire pins_type pins_in,
    // Wake sources
    input wire logic [7:0] wake_irq,
    input wire logic touch_wake,
    // Clock and reset outputs
    output logic cpu_clk_en,
    output logic hf_osc_en,
    output logic root_clk,
    output logic [3:0] periph_clk_en,
    output logic [2:0] main_osc_freq,
    output logic sys_reset_n
);

    // ****************************************
    // Synchronisers
    // ****************************************
    pins_type ff1_r, ff2_r, ff3_r, pins_s, pins_nxt;

    // A change counts only once stages two and three agree
    always_comb begin
        pins_nxt = pins_type'((ff2_r & ~(ff2_r ^ ff3_r)) | (pins_s & (ff2_r ^ ff3_r)));
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ff1_r <= pins_type'(`PINS_RST);
            ff2_r <= pins_type'(`PINS_RST);
            ff3_r <= pins_type'(`PINS_RST);
            pins_s <= pins_type'(`PINS_RST);
        end else begin
            ff1_r <= pins_in;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
            pins_s <= pins_nxt;
        end
    end

    // ****************************************
    // Bus slave
    // ****************************************
    logic wr_r, wr_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic take;
    power_mode_type mode_r, mode_nxt;
    clk_src_type clk_sel_r, clk_sel_nxt, cur_r, cur_nxt, tgt_r, tgt_nxt;
    mux_state_type mst_r, mst_nxt;
    logic [2:0] freq_r, freq_nxt;
    logic [7:0] wmask_r, wmask_nxt;
    logic touch_en_r, touch_en_nxt, wdt_en_r, wdt_en_nxt;
    logic [15:0] wdt_to_r, wdt_to_nxt, wdt_cnt_r, wdt_cnt_nxt;
    logic [3:0] cause_r, cause_nxt, clr_v, keep_v;
    div_cfg_type div_r [4];
    div_cfg_type div_nxt [4];

    // Register hit in the data phase
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    function automatic logic [23:0] int_mask(input int w);
        int_mask = 24'((32'h0000_0001 << w) - 32'h0000_0001);
    endfunction : int_mask

    assign take = hsel & htrans[1] & hready;

    // Read data is fetched in the address phase so the answer has no wait
    always_comb begin
        wr_nxt = take & hwrite;
        addr_nxt = take ? haddr[7:0] : addr_r;
        rdata_nxt = 32'h0000_0000;
        if (take && !hwrite) begin
            case (haddr[7:0])
                `OFS_MODE: rdata_nxt[`MODE_F] = mode_r;
                `OFS_CLK: begin
                    rdata_nxt[`CLK_SEL_F] = clk_sel_r;
                    rdata_nxt[`CLK_FREQ_F] = freq_r;
                end
                `OFS_WAKE: begin
                    rdata_nxt[`WMASK_F] = wmask_r;
                    rdata_nxt[`TOUCH_EN_B] = touch_en_r;
                end
                `OFS_WDT: begin
                    rdata_nxt[`WDT_TO_F] = wdt_to_r;
                    rdata_nxt[`WDT_EN_B] = wdt_en_r;
                end
                `OFS_SERVICE: rdata_nxt[`WDT_TO_F] = wdt_cnt_r;
                `OFS_CAUSE: rdata_nxt[`CAUSE_F] = cause_r;
                `OFS_STAT: begin
                    rdata_nxt[`MODE_F] = mode_r;
                    rdata_nxt[`STAT_SRC_F] = cur_r;
                    rdata_nxt[`STAT_SW_B] = (mst_r != MUX_RUN);
                    rdata_nxt[`STAT_SG_B] = pins_s.supply_good;
                end
                default: begin
                    if (haddr[7:4] == `DIV_HI) begin
                        rdata_nxt[`DIV_INT_F] = div_r[haddr[3:2]].int_part;
                        rdata_nxt[`DIV_FRAC_B] = div_r[haddr[3:2]].frac;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_r <= 1'b0;
            addr_r <= 8'h00;
            rdata_r <= 32'h0000_0000;
        end else begin
            wr_r <= wr_nxt;
            addr_r <= addr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    logic sw_rst_r, sw_rst_nxt, service_r, service_nxt;

    always_comb begin
        clk_sel_nxt = clk_sel_r;
        freq_nxt = freq_r;
        wmask_nxt = wmask_r;
        touch_en_nxt = touch_en_r;
        wdt_en_nxt = wdt_en_r;
        wdt_to_nxt = wdt_to_r;
        div_nxt = div_r;
        sw_rst_nxt = wr_r & hit(addr_r, `OFS_SWRST) & hwdata[`SWRST_B];
        service_nxt = wr_r & hit(addr_r, `OFS_SERVICE);
        clr_v = (wr_r & hit(addr_r, `OFS_CAUSE)) ? hwdata[`CAUSE_F] : 4'h0;
        if (wr_r && hit(addr_r, `OFS_CLK)) begin
            clk_sel_nxt = clk_src_type'(hwdata[`CLK_SEL_F]);
            // Codes above the top step clamp to 48 MHz
            freq_nxt = (hwdata[`CLK_FREQ_F] > `FREQ_MAX) ? `FREQ_MAX : hwdata[`CLK_FREQ_F];
        end
        if (wr_r && hit(addr_r, `OFS_WAKE)) begin
            wmask_nxt = hwdata[`WMASK_F];
            touch_en_nxt = hwdata[`TOUCH_EN_B];
        end
        if (wr_r && hit(addr_r, `OFS_WDT)) begin
            wdt_to_nxt = hwdata[`WDT_TO_F];
            wdt_en_nxt = hwdata[`WDT_EN_B];
        end
        for (int i = 0; i < 4; i++) begin
            if (wr_r && addr_r[7:4] == `DIV_HI && addr_r[3:2] == 2'(i)) begin
                // Integer width and fraction bit are fixed per divider
                div_nxt[i].int_part = hwdata[`DIV_INT_F] & int_mask(DIV_INT_W[i]);
                div_nxt[i].frac = hwdata[`DIV_FRAC_B] & DIV_FRAC[i];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_sel_r <= SRC_MAIN;
            freq_r <= 3'h0;
            wmask_r <= 8'h00;
            touch_en_r <= 1'b0;
            wdt_en_r <= 1'b0;
            wdt_to_r <= `WDT_TO_RST;
            sw_rst_r <= 1'b0;
            service_r <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                div_r[i] <= '0;
            end
        end else begin
            clk_sel_r <= clk_sel_nxt;
            freq_r <= freq_nxt;
            wmask_r <= wmask_nxt;
            touch_en_r <= touch_en_nxt;
            wdt_en_r <= wdt_en_nxt;
            wdt_to_r <= wdt_to_nxt;
            sw_rst_r <= sw_rst_nxt;
            service_r <= service_nxt;
            div_r <= div_nxt;
        end
    end

    // ****************************************
    // Glitch-free source switch
    // ****************************************
    logic [2:0] src;
    logic root_r, root_nxt, root_prev_r, root_tick;

    assign src = {pins_s.ext_clk, pins_s.lp_osc, pins_s.main_osc};

    // Let the old source finish its high phase, then hold low until the
    // new one is low, so neither a short high nor a short low gets out
    always_comb begin
        mst_nxt = mst_r;
        cur_nxt = cur_r;
        tgt_nxt = tgt_r;
        case (mst_r)
            MUX_RUN: begin
                tgt_nxt = (clk_sel_r == SRC_RSVD) ? SRC_MAIN : clk_sel_r;
                if (tgt_nxt != cur_r) begin
                    mst_nxt = MUX_DRAIN;
                end
            end
            MUX_DRAIN: begin
                if (!src[cur_r]) begin
                    mst_nxt = MUX_FILL;
                end
            end
            MUX_FILL: begin
                if (!src[tgt_r]) begin
                    cur_nxt = tgt_r;
                    mst_nxt = MUX_RUN;
                end
            end
            default: mst_nxt = MUX_RUN;
        endcase
        root_nxt = (mst_nxt == MUX_FILL) ? 1'b0 : src[cur_nxt];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mst_r <= MUX_RUN;
            cur_r <= SRC_MAIN;
            tgt_r <= SRC_MAIN;
            root_r <= 1'b0;
            root_prev_r <= 1'b0;
        end else begin
            mst_r <= mst_nxt;
            cur_r <= cur_nxt;
            tgt_r <= tgt_nxt;
            root_r <= root_nxt;
            root_prev_r <= root_r;
        end
    end

    assign root_tick = root_r & ~root_prev_r;

    // ****************************************
    // Peripheral dividers
    // ****************************************
    // Output is one enable pulse per (N + 1) root edges; with the fraction
    // set every other period is one edge longer, giving N + 1.5 on average
    for (genvar g = 0; g < 4; g++) begin : g_div
        logic [23:0] cnt_r, cnt_nxt;
        logic ph_r, ph_nxt, pulse_r, pulse_nxt;
        logic [24:0] period;

        always_comb begin
            period = {1'b0, div_r[g].int_part} + {24'h00_0000, div_r[g].frac & ph_r};
            cnt_nxt = cnt_r;
            ph_nxt = ph_r;
            pulse_nxt = 1'b0;
            if (root_tick && mode_r != MODE_DEEP) begin
                if ({1'b0, cnt_r} >= period) begin
                    cnt_nxt = 24'h00_0000;
                    ph_nxt = ~ph_r;
                    pulse_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 24'h00_0001;
                end
            end
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cnt_r <= 24'h00_0000;
                ph_r <= 1'b0;
                pulse_r <= 1'b0;
            end else begin
                cnt_r <= cnt_nxt;
                ph_r <= ph_nxt;
                pulse_r <= pulse_nxt;
            end
        end

        assign periph_clk_en[g] = pulse_r;
    end

    // ****************************************
    // Power modes
    // ****************************************
    localparam logic [15:0] WAKE_LAST = 16'(WAKE_CYCLES - 2);
    power_mode_type pend_r, pend_nxt;
    logic [15:0] wcnt_r, wcnt_nxt;
    logic cpu_en_r, cpu_en_nxt, hf_r, hf_nxt, wake_ev, rst_evt;

    // Wake logic runs on hclk, which never stops in deep sleep
    assign wake_ev = (|(wake_irq & wmask_r)) | (touch_wake & touch_en_r);

    always_comb begin
        mode_nxt = mode_r;
        pend_nxt = pend_r;
        wcnt_nxt = 16'h0000;
        case (mode_r)
            MODE_ACTIVE: begin
                // Entry held while supply is not good
                if (pend_r != MODE_ACTIVE && pins_s.supply_good) begin
                    mode_nxt = pend_r;
                    pend_nxt = MODE_ACTIVE;
                end
            end
            MODE_SLEEP: begin
                if (wake_ev) begin
                    mode_nxt = MODE_ACTIVE;
                end
            end
            MODE_DEEP: begin
                if (wake_ev) begin
                    mode_nxt = MODE_WAKE;
                end
            end
            MODE_WAKE: begin
                wcnt_nxt = wcnt_r + 16'h0001;
                if (wcnt_r >= WAKE_LAST) begin
                    mode_nxt = MODE_ACTIVE;
                    wcnt_nxt = 16'h0000;
                end
            end
            default: mode_nxt = MODE_ACTIVE;
        endcase
        if (wr_r && hit(addr_r, `OFS_MODE) && hwdata[`MODE_F] != MODE_WAKE) begin
            pend_nxt = power_mode_type'(hwdata[`MODE_F]);
        end
        if (rst_evt) begin
            mode_nxt = MODE_ACTIVE;
            pend_nxt = MODE_ACTIVE;
        end
        cpu_en_nxt = (mode_nxt == MODE_ACTIVE);
        hf_nxt = (mode_nxt != MODE_DEEP);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= MODE_ACTIVE;
            pend_r <= MODE_ACTIVE;
            wcnt_r <= 16'h0000;
            cpu_en_r <= 1'b1;
            hf_r <= 1'b1;
        end else begin
            mode_r <= mode_nxt;
            pend_r <= pend_nxt;
            wcnt_r <= wcnt_nxt;
            cpu_en_r <= cpu_en_nxt;
            hf_r <= hf_nxt;
        end
    end

    // ****************************************
    // Watchdog and reset combiner
    // ****************************************
    logic lp_prev_r, lp_tick, exp_r, exp_nxt, srst_r, srst_nxt;
    logic [7:0] rcnt_r, rcnt_nxt;

    assign lp_tick = pins_s.lp_osc & ~lp_prev_r;
    assign rst_evt = exp_r | sw_rst_r | ~pins_s.ext_rst_n | pins_s.brown_out;

    always_comb begin
        wdt_cnt_nxt = wdt_cnt_r;
        exp_nxt = 1'b0;
        if (rst_evt || !wdt_en_r || service_r) begin
            wdt_cnt_nxt = 16'h0000;
        end else if (lp_tick) begin
            // Counts on in every mode, deep sleep included
            if (wdt_cnt_r >= wdt_to_r) begin
                exp_nxt = 1'b1;
                wdt_cnt_nxt = 16'h0000;
            end else begin
                wdt_cnt_nxt = wdt_cnt_r + 16'h0001;
            end
        end
        // Level sources keep reloading, so the pulse outlasts them
        rcnt_nxt = rst_evt ? `RST_PULSE : ((rcnt_r != 8'h00) ? rcnt_r - 8'h01 : 8'h00);
        srst_nxt = (rcnt_nxt == 8'h00);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lp_prev_r <= 1'b0;
            wdt_cnt_r <= 16'h0000;
            exp_r <= 1'b0;
            rcnt_r <= 8'h00;
            srst_r <= 1'b1;
        end else begin
            lp_prev_r <= pins_s.lp_osc;
            wdt_cnt_r <= wdt_cnt_nxt;
            exp_r <= exp_nxt;
            rcnt_r <= rcnt_nxt;
            srst_r <= srst_nxt;
        end
    end

    // ****************************************
    // Reset cause, on power-on reset only
    // ****************************************
    // Set wins over a software clear in the same cycle
    always_comb begin
        keep_v = cause_r & ~clr_v;
        cause_nxt = keep_v;
        cause_nxt[`CAUSE_WDT] = keep_v[`CAUSE_WDT] | exp_r;
        cause_nxt[`CAUSE_SW] = keep_v[`CAUSE_SW] | sw_rst_r;
        cause_nxt[`CAUSE_EXTERNAL_RESET_N] = keep_v[`CAUSE_EXTERNAL_RESET_N] | ~pins_s.ext_rst_n;
        cause_nxt[`CAUSE_BOD] = keep_v[`CAUSE_BOD] | pins_s.brown_out;
    end

    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            cause_r <= 4'h0;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign hrdata = rdata_r;
    assign hreadyout = 1'b1 & srst_r | ~srst_r;
    assign hresp = 1'b0 & rdata_r[0];
    assign cpu_clk_en = cpu_en_r;
    assign hf_osc_en = hf_r;
    assign root_clk = root_r;
    assign main_osc_freq = freq_r;
    assign sys_reset_n = srst_r;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence deep_wake_s;
        mode_r == MODE_DEEP && wake_ev && !rst_evt;
    endsequence

    sequence sleep_wake_s;
        mode_r == MODE_SLEEP && wake_ev;
    endsequence

    cpu_gate_mode_a: assert property (cpu_en_r == (mode_r == MODE_ACTIVE))
        else $error("processor clock enable disagrees with mode");
    sleep_wake_fast_a: assert property (sleep_wake_s |=> cpu_en_r)
        else $error("sleep wake did not restore processor clock");
    deep_hf_off_a: assert property (mode_r == MODE_DEEP |-> !hf_r)
        else $error("main oscillator on in deep sleep");
    deep_wake_step_a: assert property (deep_wake_s |=> mode_r == MODE_WAKE)
        else $error("deep sleep wake event ignored");
    wake_bound_a: assert property (mode_r == MODE_WAKE |-> wcnt_r <= WAKE_LAST)
        else $error("deep sleep wake too slow");
    supply_hold_a: assert property (
        mode_r == MODE_ACTIVE && !pins_s.supply_good |=> mode_r == MODE_ACTIVE)
        else $error("mode entered without supply good");
    bod_reset_a: assert property (pins_s.brown_out |=> !srst_r)
        else $error("brown-out gave no reset");
    external_reset_n_reset_a: assert property (!pins_s.ext_rst_n |=> !srst_r)
        else $error("external reset pin ignored");
    wdt_reset_a: assert property (exp_r |=> !srst_r && cause_r[`CAUSE_WDT])
        else $error("watchdog expiry not reset or not recorded");
    wdt_service_a: assert property (service_r |=> wdt_cnt_r == 16'h0000)
        else $error("service did not restart watchdog");
    fill_low_a: assert property (mst_r == MUX_FILL |-> !root_r)
        else $error("root clock high during source switch");
    freq_range_a: assert property (freq_r <= `FREQ_MAX)
        else $error("main oscillator setting out of range");
    cause_sticky_a: assert property (@(posedge hclk) disable iff (!por_n)
        1'b1 |=> (cause_r & $past(keep_v)) == $past(keep_v))
        else $error("reset cause flag lost");

endmodule : clock_reset_power_mode_control

// *** dv/crpm_partner.sv ***
// Far-side model: oscillators, reset pin and supply monitors.
// Assumes it is clocked by hclk; outputs feed the pins input.
module crpm_partner
    import crpm_pkg::*;
(
    // Clock and test controls
    input wire logic hclk,
    input wire logic rst_req,
    input wire logic bod,
    // Pin levels
    output pins_type pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = 4'h0;
    // Free-running count; the low-power source is scaled down for run time
    always @(posedge hclk) cnt <= cnt + 4'h1;
    // Pin levels from the count and the test controls
    always_comb begin
        // Every level lasts two cycles or more, so the pin filter lets it through
        pins.main_osc = cnt[1];
        pins.lp_osc = cnt[3];
        pins.ext_clk = cnt[2];
        pins.ext_rst_n = !rst_req;
        pins.supply_good = 1'b1;
        pins.brown_out = bod;
    end
endmodule : crpm_partner

// *** dv/clock_reset_power_mode_control_tb.sv ***
// Bench: bus tasks and scenario calls for the mode and reset controller.
// Assumes the far-side model and a short oscillator restart wait.
module clock_reset_power_mode_control_tb
    import crpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpu, hfo, rclk, srn, rq, bod, tw;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0] htrans;
    logic [2:0] hsize, frq;
    logic [7:0] wirq;
    logic [3:0] pce;
    pins_type pins;
    int error_cnt = 0, samples_checked = 0, n;
    crpm_partner i_crpm_partner(.hclk(hclk), .rst_req(rq), .bod(bod), .pins(pins));
    clock_reset_power_mode_control #(.WAKE_CYCLES(10)) i_clock_reset_power_mode_control(
        .hclk(hclk), .hresetn(hresetn), .por_n(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pins_in(pins), .wake_irq(wirq), .touch_wake(tw), .cpu_clk_en(cpu),
        .hf_osc_en(hfo), .root_clk(rclk), .periph_clk_en(pce), .main_osc_freq(frq),
        .sys_reset_n(srn));
    // ****************************************
    // Tasks
    // ****************************************
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    // One single transfer; the address phase is held until hready is seen
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
        chk("ready_resp", {hreadyout, hresp}, 2'h2);
    endtask : xfer
    // Wait for a system reset and measure how long it stays low
    task wait_rst();
        n = 0;
        do @(posedge hclk); while (srn !== 1'b0);
        while (srn !== 1'b1) begin
            @(posedge hclk);
            n++;
        end
        chk("rst_len", n >= 16, 1);
    endtask : wait_rst
    // Cycles from one divider pulse to the m-th one after it
    task gap(input int k, input int m);
        do @(posedge hclk); while (pce[k] !== 1'b1);
        n = 0;
        repeat (m) begin
            do begin
                @(posedge hclk);
                n++;
            end while (pce[k] !== 1'b1);
        end
    endtask : gap
    task complete_run();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    // ****************************************
    // Clock, watchdog and scenarios
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // Generous span; the whole sequence needs a few hundred cycles
    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end
    initial begin
        {hresetn, hsel, hwrite, rq, bod, tw} = '0;
        {haddr, hwdata, wirq, htrans} = '0;
        hsize = 3'h2;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        chk("freq_rst", frq, 3'h0);
        xfer(0, 8'h14, 0);
        chk("cause_rst", d, 0);
        xfer(0, 8'h30, 0);
        chk("unmapped", d, 0);
        xfer(1, 8'h04, 32'h0000_0070);
        // The setting lands on the edge that ends the data phase
        @(posedge hclk);
        chk("freq_max", frq, 3'h6);
        // Each selectable source shows up in the status field
        for (int s = 2; s >= 0; s--) begin
            xfer(1, 8'h04, s);
            repeat (30) @(posedge hclk);
            xfer(0, 8'h1C, 0);
            chk("src", d[3:2], s);
        end
        // Integer width and fraction bit are fixed per divider
        xfer(1, 8'h24, 32'h81FF_FFFF);
        xfer(0, 8'h24, 0);
        chk("div1_mask", d, 32'h0000_FFFF);
        xfer(1, 8'h2C, 32'h81FF_FFFF);
        xfer(0, 8'h2C, 0);
        chk("div3_mask", d, 32'h80FF_FFFF);
        // Main source gives a root edge every fourth cycle
        xfer(1, 8'h20, 1);
        xfer(1, 8'h28, 32'h8000_0001);
        repeat (40) @(posedge hclk);
        gap(0, 1);
        chk("div_int", n, (1 + 1) * 4);
        gap(2, 2);
        chk("div_frac", n, (2 + 3) * 4);
        // Sleep, then an enabled interrupt wakes at once
        xfer(1, 8'h08, 32'h0000_0101);
        xfer(1, 8'h00, 1);
        repeat (3) @(posedge hclk);
        chk("sleep_cpu", cpu, 0);
        chk("sleep_hf", hfo, 1);
        wirq <= 8'h01;
        repeat (2) @(posedge hclk);
        chk("wake_cpu", cpu, 1);
        wirq <= 8'h00;
        // Deep sleep, touch wake, restart within the bound
        xfer(1, 8'h00, 2);
        repeat (3) @(posedge hclk);
        chk("deep_hf", hfo, 0);
        chk("deep_cpu", cpu, 0);
        tw <= 1'b1;
        @(posedge hclk);
        tw <= 1'b0;
        repeat (13) @(posedge hclk);
        chk("deep_wake", {hfo, cpu}, 2'h3);
        // Software, pin and brown-out resets each leave their own flag
        for (int i = 1; i < 4; i++) begin
            if (i == 1) xfer(1, 8'h18, 1);
            else begin
                rq <= (i == 2);
                bod <= (i == 3);
                repeat (6) @(posedge hclk);
                {rq, bod} <= 2'h0;
            end
            wait_rst();
            xfer(0, 8'h14, 0);
            chk("cause", d, 32'h1 << i);
            xfer(1, 8'h14, 32'h1 << i);
            xfer(0, 8'h14, 0);
            chk("cause_clr", d, 0);
        end
        // Watchdog left unserviced expires and is recorded
        xfer(1, 8'h0C, 32'h0001_0002);
        wait_rst();
        xfer(1, 8'h0C, 0);
        xfer(0, 8'h14, 0);
        chk("cause_wdt", d, 1);
        complete_run();
    end
endmodule : clock_reset_power_mode_control_tb
